// *** include/scan_pkg.sv ***
// Constants for the pin continuity scan block.
// Assumes a 200 MHz system clock sampling the scan select and scan clock.
package scan_pkg;
  // Pin counts of each phase
  localparam int OUT_PINS = 17;
  localparam int BIDIR_PINS = 17;
  localparam int IN_PINS = 33;
  localparam int OUT_STEPS = OUT_PINS + BIDIR_PINS;
  localparam int IN_STEPS = IN_PINS + BIDIR_PINS;
  // Output steps, input steps, then one release clock
  localparam int SEQ_LEN = OUT_STEPS + IN_STEPS + 1;
  localparam int STEP_W = 7;
  localparam logic [6:0] LAST_STEP = 7'(SEQ_LEN - 1);
  localparam logic [6:0] IN_FIRST = 7'(OUT_STEPS);
  localparam logic [6:0] STEP_RST = 7'h00;
  // Pin vector widths
  localparam int OE_W = OUT_PINS + BIDIR_PINS;
  localparam int SMP_W = IN_PINS + BIDIR_PINS;
  typedef enum logic [1:0] {st_normal, st_wait, st_scan} scan_state_t;
endpackage : scan_pkg

// *** verilog/edge_sync.sv ***
// Two flip-flop synchroniser with falling edge detect.
// Assumes input comes from outside the sys_clk domain.
`timescale 1ns/1ps
module edge_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic din,
  output logic level,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic [2:0] fill_r;
  // Synchronise and keep previous value for edge detection
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      fill_r <= 3'h0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end
  assign level = sync_r;
  // Edges count only once the pipe holds real pin samples, so a pin that
  // idles low gives no false fall after reset
  assign fall = fill_r[2] & prev_r & ~sync_r;
endmodule : edge_sync

// *** verilog/pin_scan.sv ***
// Pin continuity scan test: walking zero out, serial readback of inputs.
// Assumes pin vectors are in package walking order, index 0 first.
`timescale 1ns/1ps
module pin_scan (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scan_sel_n,
  input wire logic aen,
  input wire logic [scan_pkg::SMP_W-1:0] in_pins,
  output logic [scan_pkg::OE_W-1:0] pin_out,
  output logic [scan_pkg::OE_W-1:0] pin_oe,
  output logic prom_out,
  output logic prom_oe,
  output logic scan_active,
  output logic core_rst_n,
  output logic bus_aen
);
  logic sel_lvl;
  logic aen_lvl;
  logic aen_fall;
  logic [scan_pkg::SMP_W-1:0] smp_meta_r;
  logic [scan_pkg::SMP_W-1:0] smp_r;
  scan_pkg::scan_state_t state_r;
  scan_pkg::scan_state_t state_nxt;
  logic [6:0] step_r;
  logic [6:0] step_nxt;
  logic started_r;
  logic started_nxt;
  logic prom_r;
  logic prom_nxt;
  logic prom_oe_r;
  logic prom_oe_nxt;
  logic [scan_pkg::OE_W-1:0] oe_r;
  logic [scan_pkg::OE_W-1:0] oe_nxt;

  // Synchronise select pin and scan clock
  edge_sync u_sel (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(scan_sel_n),
    .level(sel_lvl),
    .fall()
  );
  edge_sync u_aen (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(aen),
    .level(aen_lvl),
    .fall(aen_fall)
  );

  // Two-stage sampling of tested inputs; analog pins are not wired
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      smp_meta_r <= '0;
      smp_r <= '0;
    end else begin
      smp_meta_r <= in_pins;
      smp_r <= smp_meta_r;
    end
  end

  // Decode of phase and pin index
  wire in_scan = (state_r == scan_pkg::st_scan);
  wire at_last = (step_r == scan_pkg::LAST_STEP);
  wire out_phase = started_r && (step_r < scan_pkg::IN_FIRST);
  wire in_phase = started_r && !out_phase && !at_last;

  // Mode control and step sequencing
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    started_nxt = started_r;
    case (state_r)
      scan_pkg::st_normal: begin
        if (!sel_lvl) begin
          // Entry only counts when the scan clock was low first
          state_nxt = aen_lvl ? scan_pkg::st_wait : scan_pkg::st_scan;
          step_nxt = scan_pkg::STEP_RST;
          started_nxt = 1'b0;
        end
      end
      scan_pkg::st_wait: begin
        if (sel_lvl) begin
          state_nxt = scan_pkg::st_normal;
        end
      end
      scan_pkg::st_scan: begin
        if (sel_lvl) begin
          state_nxt = scan_pkg::st_normal;
          started_nxt = 1'b0;
        end else if (aen_fall) begin
          if (!started_r) begin
            started_nxt = 1'b1; // first edge lights first pin
            step_nxt = scan_pkg::STEP_RST;
          end else if (at_last) begin
            step_nxt = scan_pkg::STEP_RST;
          end else begin
            step_nxt = step_r + 7'h01;
          end
        end
      end
      default: state_nxt = scan_pkg::st_normal;
    endcase
  end

  // Output enables: one pin driven low in the output phase
  genvar gi;
  generate
    for (gi = 0; gi < scan_pkg::OE_W; gi++) begin : g_oe
      assign oe_nxt[gi] = (state_nxt == scan_pkg::st_scan) && started_nxt
        && (step_nxt == 7'(gi));
    end
  endgenerate

  // Prom pin enable and data follow the next step, so both switch together
  wire in_phase_nxt = (state_nxt == scan_pkg::st_scan) && started_nxt
    && (step_nxt >= scan_pkg::IN_FIRST)
    && (step_nxt != scan_pkg::LAST_STEP);
  wire [6:0] in_idx = step_nxt - scan_pkg::IN_FIRST;
  wire idx_ok = (in_idx < 7'(scan_pkg::SMP_W));
  wire sel_bit = idx_ok ? smp_r[in_idx[5:0]] : 1'b0;
  assign prom_oe_nxt = in_phase_nxt;
  assign prom_nxt = in_phase_nxt ? sel_bit : prom_r;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= scan_pkg::st_normal;
      step_r <= scan_pkg::STEP_RST;
      started_r <= 1'b0;
      prom_r <= 1'b0;
      prom_oe_r <= 1'b0;
      oe_r <= '0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      started_r <= started_nxt;
      prom_r <= prom_nxt;
      prom_oe_r <= prom_oe_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Pin drivers and mode outputs
  assign pin_out = '0;
  assign pin_oe = oe_r;
  assign prom_out = prom_r;
  assign prom_oe = prom_oe_r;
  assign scan_active = in_scan;
  assign core_rst_n = !in_scan;
  assign bus_aen = in_scan ? 1'b0 : aen_lvl;

  // Checks
  a_reset_held: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && !sel_lvl |=> !core_rst_n) else $error("core not in reset");
  a_aen_blocked: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && !sel_lvl |=> !bus_aen) else $error("aen leaked to bus");
  a_onehot_oe: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $onehot0(pin_oe)) else $error("more than one pin driven");
  a_entry_float: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(in_scan) |-> pin_oe == '0 && !prom_oe)
    else $error("pins driven on entry");
  a_first_pin: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && !started_r && aen_fall && !sel_lvl |=> pin_oe[0])
    else $error("walk not at first pin");
  a_wrap_len: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && at_last && aen_fall && !sel_lvl |=> step_r == 7'h00)
    else $error("sequence length wrong");
  a_last_float: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && at_last |-> pin_oe == '0 && !prom_oe)
    else $error("release clock drives");
  a_exit_normal: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && sel_lvl |=> !in_scan) else $error("no exit");
  a_no_enter_high: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_r == scan_pkg::st_normal && aen_lvl |=> !in_scan)
    else $error("entered with aen high");
  a_step_range: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    step_r <= scan_pkg::LAST_STEP) else $error("step past end");
  a_step_adv: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && started_r && !at_last && aen_fall && !sel_lvl
    |=> step_r == $past(step_r) + 7'h01) else $error("step not advanced");
  a_step_hold: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && !aen_fall |=> $stable(step_r)) else $error("step moved");
  a_out_window: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (|pin_oe) |-> in_scan && started_r && step_r < scan_pkg::IN_FIRST)
    else $error("pin driven outside output phase");
  a_out_index: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan && started_r && step_r < scan_pkg::IN_FIRST
    |-> pin_oe[step_r[5:0]]) else $error("wrong pin driven");
  a_prom_window: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    in_scan |-> prom_oe == in_phase) else $error("prom enable wrong");
  a_exit_float: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !in_scan |-> pin_oe == '0 && !prom_oe)
    else $error("pins driven outside scan");

  // Scenario covers
  c_enter: cover property (@(posedge sys_clk) disable iff (!nrst)
    $rose(in_scan));
  c_input: cover property (@(posedge sys_clk) disable iff (!nrst)
    prom_oe);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!nrst)
    in_scan && at_last && aen_fall);
  c_refused: cover property (@(posedge sys_clk) disable iff (!nrst)
    state_r == scan_pkg::st_wait);
  c_exit: cover property (@(posedge sys_clk) disable iff (!nrst)
    $fell(in_scan));
endmodule : pin_scan

// *** bench/board_tester.sv ***
// Board tester model: drives scan select and the scan clock on aen.
// Assumes the bench lowers run only while aen is low.
`timescale 1ns/1ps
module board_tester (
  input wire logic sel_req,
  input wire logic run,
  input wire logic park_high,
  output logic scan_sel_n,
  output logic aen
);
  initial aen = 1'b0;
  // 160 ns scan clock, parked at a fixed level between frames
  always begin
    #80;
    aen = run ? ~aen : park_high; // parked at the park_high level while run is low
  end
  // Select follows the request; active low on the pin
  assign scan_sel_n = ~sel_req;
endmodule : board_tester

// *** bench/pin_continuity_scan_test_tb_top.sv ***
// Self-checking bench for the pin continuity scan block.
// Assumes board_tester supplies select and aen; in_pins random.
`timescale 1ns/1ps
module pin_continuity_scan_test_tb_top;
  logic sys_clk = 1'b0, nrst = 1'b0, sel_req = 1'b0, run = 1'b0;
  logic park_high = 1'b0, scan_sel_n, aen;
  logic [scan_pkg::SMP_W-1:0] in_pins = '0;
  logic [scan_pkg::OE_W-1:0] pin_out, pin_oe;
  logic prom_out, prom_oe, scan_active, core_rst_n, bus_aen;
  int num_errors = 0, tests_run = 0, cycles = 0, seed = 32'h3870;
  board_tester u_board_tester (.sel_req(sel_req), .run(run),
    .park_high(park_high), .scan_sel_n(scan_sel_n), .aen(aen));
  pin_scan u_pin_scan (.sys_clk(sys_clk), .nrst(nrst),
    .scan_sel_n(scan_sel_n), .aen(aen), .in_pins(in_pins),
    .pin_out(pin_out), .pin_oe(pin_oe), .prom_out(prom_out),
    .prom_oe(prom_oe), .scan_active(scan_active),
    .core_rst_n(core_rst_n), .bus_aen(bus_aen));
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // Expected enables: walking one over 34 pins, then none
  function automatic logic [33:0] exp_oe(input int k);
    return (k < 34) ? (34'h1 << k) : 34'h0;
  endfunction : exp_oe
  task automatic check_vec(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t vector %h expected %h", $time, got, exp);
    end
  endtask : check_vec
  task automatic check_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s is %b", $time, m, got);
    end
  endtask : check_bit
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk
  // One scan clock fall, fresh pin levels, then check step k
  task automatic fall_check(input int k);
    @(negedge aen);
    @(posedge sys_clk);
    in_pins <= 50'({$random(seed), $random(seed)});
    wait_clk(8);
    check_vec(pin_oe, exp_oe(k));
    check_vec(pin_out, 34'h0);
    check_bit(prom_oe, k >= 34 && k < 84, "prom_oe");
    if (k >= 34 && k < 84) check_bit(prom_out, in_pins[k-34], "prom");
  endtask : fall_check
  task automatic test_done;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    wait_clk(20);
    nrst <= 1'b1;
    wait_clk(4);
    check_bit(scan_active, 1'b0, "idle mode");
    check_bit(core_rst_n, 1'b1, "core reset");
    run <= 1'b1;
    @(posedge aen);
    wait_clk(8);
    check_bit(bus_aen, 1'b1, "bus aen high");
    @(negedge aen);
    wait_clk(8);
    check_bit(bus_aen, 1'b0, "bus aen low");
    run <= 1'b0;
    wait_clk(40);
    sel_req <= 1'b1;
    wait_clk(8);
    check_bit(scan_active, 1'b1, "scan entry");
    check_bit(core_rst_n, 1'b0, "core held");
    check_vec(pin_oe, 34'h0);
    run <= 1'b1;
    for (int k = 0; k < 170; k++) fall_check(k % 85);
    check_bit(bus_aen, 1'b0, "bus aen blocked");
    run <= 1'b0;
    sel_req <= 1'b0;
    wait_clk(8);
    check_bit(scan_active, 1'b0, "scan exit");
    check_bit(core_rst_n, 1'b1, "core free");
    park_high <= 1'b1;
    wait_clk(40);
    sel_req <= 1'b1;
    wait_clk(8);
    check_bit(scan_active, 1'b0, "refused entry");
    sel_req <= 1'b0;
    park_high <= 1'b0;
    wait_clk(40);
    sel_req <= 1'b1;
    wait_clk(8);
    run <= 1'b1;
    for (int k = 0; k < 10; k++) fall_check(k);
    run <= 1'b0;
    sel_req <= 1'b0;
    wait_clk(8);
    sel_req <= 1'b1;
    wait_clk(8);
    run <= 1'b1;
    for (int k = 0; k < 2; k++) fall_check(k);
    run <= 1'b0;
    test_done();
  end
endmodule : pin_continuity_scan_test_tb_top
